// ### hdl/ptg_pkg.sv
// constants, register map and carrier types of the pattern generator
// assumes one clock at 20 MHz and an external indirect register access path
package ptg_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] OFF_CONTROL = 8'h01;
   localparam logic [7:0] OFF_CONFIG = 8'h02;
   localparam logic [7:0] OFF_TYPE_CHANNEL = 8'h03;
   localparam logic [7:0] OFF_LINE_HI = 8'h04;
   localparam logic [7:0] OFF_LINE_LO = 8'h05;
   localparam logic [7:0] OFF_STRIPE_HI = 8'h06;
   localparam logic [7:0] OFF_STRIPE_LO = 8'h07;
   localparam logic [7:0] OFF_ACTIVE_HI = 8'h08;
   localparam logic [7:0] OFF_ACTIVE_LO = 8'h09;
   localparam logic [7:0] OFF_TOTAL_HI = 8'h0A;
   localparam logic [7:0] OFF_TOTAL_LO = 8'h0B;
   localparam logic [7:0] OFF_PERIOD_HI = 8'h0C;
   localparam logic [7:0] OFF_PERIOD_LO = 8'h0D;
   localparam logic [7:0] OFF_BLANK_AFTER = 8'h0E;
   localparam logic [7:0] OFF_BLANK_BEFORE = 8'h0F;
   localparam logic [7:0] OFF_PATTERN0 = 8'h10;
   localparam logic [7:0] OFF_LAST = 8'h1F;
   localparam int REG_COUNT = 32;
   localparam int PATTERN_BYTES = 16;

   // ==========================================================
   // field positions and reset values
   localparam int CTL_ENABLE_BIT = 0;
   localparam int CFG_BARS_LSB = 0;
   localparam int CFG_FIXED_BIT = 3;
   localparam int CFG_BLOCK_LSB = 4;
   localparam int DI_TYPE_LSB = 0;
   localparam int DI_CHANNEL_LSB = 6;
   localparam logic [7:0] CONFIG_RESET = 8'h03;
   localparam logic [7:0] OTHER_RESET = 8'h00;

   // ==========================================================
   // packet codes and bar values
   localparam logic [5:0] DT_FRAME_START = 6'h00;
   localparam logic [5:0] DT_FRAME_END = 6'h01;
   localparam logic [7:0] BAR_VALUE [8] =
      '{8'hAA, 8'h33, 8'hF0, 8'h7F, 8'h55, 8'hCC, 8'h0F, 8'h80};
   localparam logic [7:0] INVERT_MASK = 8'hFF;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int PERIOD_UNIT_NS = 10;
   localparam logic [16:0] UNITS_PER_CLK = 17'(CLK_PERIOD_NS / PERIOD_UNIT_NS);

   // ==========================================================
   // types
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_BODY = 1'b1
   } ptg_state_t;

   typedef struct packed {
      logic valid;
      logic header;
      logic isShort;
      logic [1:0] channel;
      logic [5:0] dataType;
      logic [15:0] wordCount;
      logic [7:0] data;
      logic last;
   } ptg_tx_t;

   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ptg_reg_req_t;

   function automatic logic [15:0] join16(input logic [7:0] hi, input logic [7:0] lo);
      return {hi, lo};
   endfunction
endpackage

// ### hdl/ptg_byte_source.sv
// byte generator for one line: color bars or repeating fixed block
// assumes the caller pulses lineStart before each line and advance per byte taken
`timescale 1ns/1ns
`default_nettype none
module ptg_byte_source (
   input wire logic clk,
   input wire logic rstn,
   input wire logic lineStart,
   input wire logic advance,
   input wire logic fixedMode,
   input wire logic [1:0] barSel,
   input wire logic [15:0] barBytes,
   input wire logic [3:0] blockCode,
   input wire logic [8*ptg_pkg::PATTERN_BYTES-1:0] pattern,
   output logic [7:0] data
);
   logic [15:0] barCnt;
   logic [2:0] barIdx;
   logic [3:0] blkIdx;
   wire logic [2:0] lastBar = 3'((1 << barSel) - 1);
   wire logic barEnd = (barCnt + 16'h0001 >= barBytes);
   wire logic onLastBar = (barIdx == lastBar);
   wire logic [3:0] blkLast = blockCode - 4'h1;
   wire logic [7:0] fixedByte = pattern[8*blkIdx +: 8];
   wire logic [7:0] fixedOut = barIdx[0] ? (fixedByte ^ ptg_pkg::INVERT_MASK) : fixedByte;
   assign data = fixedMode ? fixedOut : ptg_pkg::BAR_VALUE[barIdx];

   // ==========================================================
   // counters
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         barCnt <= 16'h0000;
         barIdx <= 3'h0;
         blkIdx <= 4'h0;
      end else if (lineStart) begin
         barCnt <= 16'h0000;
         barIdx <= 3'h0;
         blkIdx <= 4'h0;
      end else if (advance) begin
         blkIdx <= (blkIdx == blkLast) ? 4'h0 : blkIdx + 4'h1;
         if (barEnd && !onLastBar) begin
            barCnt <= 16'h0000;
            barIdx <= barIdx + 3'h1;
         end else if (!onLastBar) begin
            barCnt <= barCnt + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// ### hdl/ptg_generator.sv
// pattern generator top: register page, frame timing and packet stream
// assumes the indirect access path decodes the page and passes offset accesses here
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - first four bars carry AA 33 F0 7F
// - bars five to seven carry 55 CC 0F
// - eighth bar 0x80, fills line remainder
// - bar count one, two, four or eight
// - line and bar lengths programmable in bytes
// - line packets carry programmed data type, all packets channel
// - active rows within programmed total rows
// - line starts spaced by period in 10ns
// - front porch blank rows before frame end
// - back porch blank rows after frame start
// - runs on transmit clock, formats packets itself
// - fixed mode reuses dimensions, repeats block
// - fixed mode bars alternate block and inverse
// - fixed block size up to sixteen bytes
// - sixteen byte registers hold the block
// - two pattern types on page zero
module ptg_generator (
   input wire logic clk,
   input wire logic rstn,
   input wire ptg_pkg::ptg_reg_req_t regReq,
   output logic [7:0] regRdata,
   input wire logic txReady,
   output ptg_pkg::ptg_tx_t txOut
);
   // ==========================================================
   // register page
   logic [7:0] regs [ptg_pkg::REG_COUNT];
   wire logic regHit = (regReq.addr >= ptg_pkg::OFF_CONTROL) &&
      (regReq.addr <= ptg_pkg::OFF_LAST);
   wire logic [4:0] regIdx = regReq.addr[4:0];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < ptg_pkg::REG_COUNT; i++) begin
            regs[i] <= ptg_pkg::OTHER_RESET;
         end
         regs[ptg_pkg::OFF_CONFIG[4:0]] <= ptg_pkg::CONFIG_RESET;
      end else if (regReq.write && regHit) begin
         regs[regIdx] <= regReq.wdata;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         regRdata <= 8'h00;
      end else if (regReq.read) begin
         regRdata <= regHit ? regs[regIdx] : 8'h00;
      end
   end

   // ==========================================================
   // field decode
   wire logic [7:0] ctl = regs[ptg_pkg::OFF_CONTROL[4:0]];
   wire logic [7:0] cfg = regs[ptg_pkg::OFF_CONFIG[4:0]];
   wire logic [7:0] di = regs[ptg_pkg::OFF_TYPE_CHANNEL[4:0]];
   wire logic enable = ctl[ptg_pkg::CTL_ENABLE_BIT];
   wire logic fixedMode = cfg[ptg_pkg::CFG_FIXED_BIT];
   wire logic [1:0] barSel = cfg[ptg_pkg::CFG_BARS_LSB +: 2];
   wire logic [3:0] blockCode = cfg[ptg_pkg::CFG_BLOCK_LSB +: 4];
   wire logic [5:0] dataType = di[ptg_pkg::DI_TYPE_LSB +: 6];
   wire logic [1:0] channel = di[ptg_pkg::DI_CHANNEL_LSB +: 2];
   wire logic [15:0] lineBytes = ptg_pkg::join16(regs[ptg_pkg::OFF_LINE_HI[4:0]],
      regs[ptg_pkg::OFF_LINE_LO[4:0]]);
   wire logic [15:0] barBytes = ptg_pkg::join16(regs[ptg_pkg::OFF_STRIPE_HI[4:0]],
      regs[ptg_pkg::OFF_STRIPE_LO[4:0]]);
   wire logic [15:0] activeRows = ptg_pkg::join16(regs[ptg_pkg::OFF_ACTIVE_HI[4:0]],
      regs[ptg_pkg::OFF_ACTIVE_LO[4:0]]);
   wire logic [15:0] totalRows = ptg_pkg::join16(regs[ptg_pkg::OFF_TOTAL_HI[4:0]],
      regs[ptg_pkg::OFF_TOTAL_LO[4:0]]);
   wire logic [15:0] rowPeriod = ptg_pkg::join16(regs[ptg_pkg::OFF_PERIOD_HI[4:0]],
      regs[ptg_pkg::OFF_PERIOD_LO[4:0]]);
   wire logic [7:0] blankAfter = regs[ptg_pkg::OFF_BLANK_AFTER[4:0]];
   wire logic [7:0] blankBefore = regs[ptg_pkg::OFF_BLANK_BEFORE[4:0]];

   logic [8*ptg_pkg::PATTERN_BYTES-1:0] pattern;
   always_comb begin
      for (int i = 0; i < ptg_pkg::PATTERN_BYTES; i++) begin
         pattern[8*i +: 8] = regs[int'(ptg_pkg::OFF_PATTERN0) + i];
      end
   end

   // ==========================================================
   // line period timing
   logic [16:0] periodAcc;
   wire logic [16:0] accSum = periodAcc + ptg_pkg::UNITS_PER_CLK;
   wire logic lineTick = enable && (accSum >= {1'b0, rowPeriod});
   wire logic [16:0] next_periodAcc = !enable ? 17'h00000 :
      lineTick ? accSum - {1'b0, rowPeriod} : accSum;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         periodAcc <= 17'h00000;
      end else begin
         periodAcc <= next_periodAcc;
      end
   end

   // ==========================================================
   // row sequencing
   logic [15:0] row;
   wire logic [16:0] firstActive = {9'h000, blankAfter};
   wire logic [16:0] endActive = firstActive + {1'b0, activeRows};
   wire logic [16:0] endRow = endActive + {9'h000, blankBefore};
   wire logic rowIsActive = ({1'b0, row} >= firstActive) && ({1'b0, row} < endActive);
   wire logic rowIsFirst = (row == 16'h0000);
   wire logic rowIsEnd = ({1'b0, row} == endRow);
   wire logic rowWrap = (row + 16'h0001 >= totalRows);
   wire logic [15:0] next_row = !enable ? 16'h0000 :
      !lineTick ? row : rowWrap ? 16'h0000 : row + 16'h0001;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         row <= 16'h0000;
      end else begin
         row <= next_row;
      end
   end

   // ==========================================================
   // pending packets, frame start before line before frame end
   logic pendStart;
   logic pendLine;
   logic pendEnd;
   ptg_pkg::ptg_state_t state;
   logic [15:0] bytesLeft;
   wire logic slotFree = !txOut.valid || txReady;
   wire logic idleFree = (state == ptg_pkg::ST_IDLE) && slotFree;
   wire logic takeStart = idleFree && pendStart;
   wire logic takeLine = idleFree && !pendStart && pendLine;
   wire logic takeEnd = idleFree && !pendStart && !pendLine && pendEnd;
   wire logic takeByte = (state == ptg_pkg::ST_BODY) && slotFree;
   wire logic lastByte = (bytesLeft == 16'h0001);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pendStart <= 1'b0;
         pendLine <= 1'b0;
         pendEnd <= 1'b0;
      end else if (!enable) begin
         pendStart <= 1'b0;
         pendLine <= 1'b0;
         pendEnd <= 1'b0;
      end else begin
         pendStart <= (lineTick && rowIsFirst) || (pendStart && !takeStart);
         pendLine <= (lineTick && rowIsActive) || (pendLine && !takeLine);
         pendEnd <= (lineTick && rowIsEnd) || (pendEnd && !takeEnd);
      end
   end

   // ==========================================================
   // packet state machine
   wire ptg_pkg::ptg_state_t next_state = takeLine && (lineBytes != 16'h0000) ?
      ptg_pkg::ST_BODY : (takeByte && lastByte) ? ptg_pkg::ST_IDLE : state;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= ptg_pkg::ST_IDLE;
         bytesLeft <= 16'h0000;
      end else begin
         state <= next_state;
         if (takeLine) begin
            bytesLeft <= lineBytes;
         end else if (takeByte) begin
            bytesLeft <= bytesLeft - 16'h0001;
         end
      end
   end

   // ==========================================================
   // byte source
   logic [7:0] srcByte;
   ptg_byte_source byteSource (
      .clk(clk),
      .rstn(rstn),
      .lineStart(takeLine),
      .advance(takeByte),
      .fixedMode(fixedMode),
      .barSel(barSel),
      .barBytes(barBytes),
      .blockCode(blockCode),
      .pattern(pattern),
      .data(srcByte)
   );

   // ==========================================================
   // transmitter output register
   ptg_pkg::ptg_tx_t next_tx;
   always_comb begin
      next_tx = txOut;
      if (slotFree) begin
         next_tx.valid = takeStart || takeLine || takeEnd || takeByte;
         next_tx.header = takeStart || takeLine || takeEnd;
         next_tx.isShort = takeStart || takeEnd;
         next_tx.channel = channel;
         next_tx.dataType = takeStart ? ptg_pkg::DT_FRAME_START :
            takeEnd ? ptg_pkg::DT_FRAME_END : dataType;
         next_tx.wordCount = takeLine ? lineBytes : 16'h0000;
         next_tx.data = takeByte ? srcByte : 8'h00;
         next_tx.last = takeByte ? lastByte :
            (takeStart || takeEnd || (takeLine && lineBytes == 16'h0000));
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         txOut <= '0;
      end else begin
         txOut <= next_tx;
      end
   end
endmodule
`default_nettype wire

// ### bench/ptg_generator_monitor.sv
// port checker of the pattern generator
// assumes the generator's top ports; bound after the module
`timescale 1ns/1ns
`default_nettype none
module ptg_generator_monitor (
   input wire logic clk,
   input wire logic rstn,
   input wire ptg_pkg::ptg_reg_req_t regReq,
   input wire logic [7:0] regRdata,
   input wire logic txReady,
   input wire ptg_pkg::ptg_tx_t txOut
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // bytes still owed to the current long packet
   logic [15:0] left;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         left <= 16'h0000;
      end else if (txOut.valid && txReady) begin
         left <= txOut.header ? txOut.wordCount : left - 16'h0001;
      end
   end
   // ==========================================================
   // properties
   property p_hold;
      txOut.valid && !txReady |=> $stable(txOut);
   endproperty
   a_hold: assert property (p_hold) else $error("item moved while stalled");
   property p_short;
      txOut.valid && txOut.isShort |-> txOut.header && txOut.last && txOut.wordCount == 16'h0000;
   endproperty
   a_short: assert property (p_short) else $error("bad short packet");
   property p_short_type;
      txOut.valid && txOut.isShort |-> txOut.dataType inside {6'h00, 6'h01};
   endproperty
   a_short_type: assert property (p_short_type) else $error("bad frame code");
   property p_hdr_data;
      txOut.valid && txOut.header |-> txOut.data == 8'h00;
   endproperty
   a_hdr_data: assert property (p_hdr_data) else $error("header data");
   property p_hdr_last;
      txOut.valid && txOut.header && !txOut.isShort |-> txOut.last == (txOut.wordCount == 16'h0000);
   endproperty
   a_hdr_last: assert property (p_hdr_last) else $error("header last");
   property p_bytes;
      txOut.valid && !txOut.header |-> left != 16'h0000 && txOut.last == (left == 16'h0001);
   endproperty
   a_bytes: assert property (p_bytes) else $error("byte count");
   property p_unmapped;
      regReq.read && (regReq.addr == 8'h00 || regReq.addr > 8'h1F) |=> regRdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_readback;
      regReq.write && regReq.addr inside {[8'h01:8'h1F]} ##1
         regReq.read && regReq.addr == $past(regReq.addr) |=> regRdata == $past(regReq.wdata, 2);
   endproperty
   a_readback: assert property (p_readback) else $error("readback");
   property p_reset_idle;
      $rose(rstn) |-> !txOut.valid ##1 !txOut.valid;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("busy after reset");
endmodule
bind ptg_generator ptg_generator_monitor i_ptg_generator_monitor (.clk(clk), .rstn(rstn),
   .regReq(regReq), .regRdata(regRdata), .txReady(txReady), .txOut(txOut));
`default_nettype wire

// ### bench/ptg_tx_sink.sv
// transmitter stand-in: takes stream items, stalls on demand
// assumes one clock shared with the generator
`timescale 1ns/1ns
`default_nettype none
module ptg_tx_sink (
   input wire logic clk,
   input wire logic rstn,
   input wire logic stall,
   output logic txReady
);
   logic [7:0] lfsr;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lfsr <= 8'h5A;
         txReady <= 1'b0;
      end else begin
         lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         txReady <= !stall || lfsr[0];
      end
   end
endmodule
`default_nettype wire

// ### bench/ptg_generator_tb.sv
// self-checking bench of the pattern generator
// assumes ptg_tx_sink as transmitter and the bound checker
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, x, g) begin compares++; if ((g) !== (x)) begin errors++; \
   $display("CHECK FAILED %s exp %h got %h", n, x, g); end end
module ptg_generator_tb;
   localparam logic [7:0] GEO [12] = '{8'h00, 8'h1A, 8'h00, 8'h03, 8'h00, 8'h02,
      8'h00, 8'h06, 8'h01, 8'h90, 8'h01, 8'h01};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic stall = 1'b0;
   logic txReady;
   logic [7:0] regRdata;
   ptg_pkg::ptg_reg_req_t regReq = '0;
   ptg_pkg::ptg_tx_t txOut;
   logic [31:0] seed = 32'd57;
   logic [25:0] txQ[$];
   logic [7:0] rdQ[$];
   logic [7:0] val[33];
   logic [25:0] e;
   logic [7:0] d;
   logic [7:0] ptc;
   logic rdWait = 1'b0;
   int errors = 0;
   int compares = 0;
   time lastHdr = 0;
   time lastFs = 0;
   always #25 clk = ~clk;
   ptg_generator i_ptg_generator (.clk(clk), .rstn(rstn), .regReq(regReq),
      .regRdata(regRdata), .txReady(txReady), .txOut(txOut));
   ptg_tx_sink i_ptg_tx_sink (.clk(clk), .rstn(rstn), .stall(stall), .txReady(txReady));
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic [25:0] key(input ptg_pkg::ptg_tx_t t);
      if (t.header) return {1'b1, t.isShort, t.channel, t.dataType, t.wordCount};
      return {17'h0, t.data, t.last};
   endfunction
   // ==========================================================
   // drivers
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      regReq <= '{w, !w, a, v};
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      acc(1'b0, a, 8'h00);
      rdQ.push_back(x);
   endtask
   task automatic idle();
      @(posedge clk);
      regReq <= '0;
   endtask
   task automatic close_out();
      $display("counts: %0d compares, %0d errors", compares, errors);
      if (errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic frame(input logic [7:0] cfg, input int reps);
      int n;
      int bar;
      int nb;
      int bs;
      nb = 1 << cfg[1:0];
      bs = cfg[7:4] == 4'h0 ? 16 : int'(cfg[7:4]);
      ptc = rnd();
      lastHdr = 0;
      lastFs = 0;
      stall <= cfg[0];
      acc(1'b1, 8'h03, ptc);
      acc(1'b1, 8'h02, cfg);
      idle();
      for (int f = 0; f < reps; f++) begin
         txQ.push_back({2'b11, ptc[7:6], 6'h00, 16'h0});
         for (int r = 0; r < 2; r++) begin
            txQ.push_back({2'b10, ptc, 16'd26});
            for (int i = 0; i < 26; i++) begin
               bar = i / 3 < nb ? i / 3 : nb - 1;
               txQ.push_back({17'h0, cfg[3] ? val[16 + i % bs] ^ {8{bar[0]}} :
                  ptg_pkg::BAR_VALUE[bar], i == 25});
            end
         end
         txQ.push_back({2'b11, ptc[7:6], 6'h01, 16'h0});
      end
      acc(1'b1, 8'h01, 8'h01);
      idle();
      for (n = 0; n < 3000 && txQ.size() > 0; n++) @(posedge clk);
      acc(1'b1, 8'h01, 8'h00);
      idle();
      if (n == 3000) begin
         errors++;
         close_out();
      end else begin
         $display("frame %h done", cfg);
      end
   endtask
   // ==========================================================
   // watcher
   always @(posedge clk) begin
      if (rdWait) begin
         e = {18'h0, rdQ.pop_front()};
         `CHK("regRdata", e[7:0], regRdata)
      end
      rdWait <= regReq.read;
      if (txOut.valid && txReady) begin
         if (txQ.size() == 0) `CHK("extra item", 1'b0, 1'b1)
         else begin
            e = txQ.pop_front();
            `CHK("tx item", e, key(txOut))
         end
         if (txOut.header && !txOut.isShort) begin
            if (!stall && lastHdr != 0) `CHK("row spacing", 64'd4000, $time - lastHdr)
            lastHdr = $time;
         end
         if (txOut.header && txOut.isShort && txOut.dataType == ptg_pkg::DT_FRAME_START) begin
            if (!stall && lastFs != 0) `CHK("frame spacing", 64'd24000, $time - lastFs)
            lastFs = $time;
            lastHdr = 0;
         end
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      for (int a = 0; a < 33; a++) rd(a[7:0], a == 2 ? 8'h03 : 8'h00);
      for (int a = 0; a < 33; a++) begin
         d = rnd() & (a == 1 ? 8'hFE : 8'hFF);
         val[a] = a % 32 == 0 ? 8'h00 : d;
         acc(1'b1, a[7:0], d);
         rd(a[7:0], val[a]);
      end
      for (int a = 4; a < 16; a++) acc(1'b1, a[7:0], GEO[a - 4]);
      idle();
      $display("register test done");
      for (int k = 0; k < 4; k++) frame({6'h00, k[1:0]}, 1);
      frame(8'h5B, 1);
      frame(8'h0A, 2);
      close_out();
   end
endmodule
`default_nettype wire
